// File: sram_tap_instruction_decode.sv
// Scan test port: state machine, instruction decode and scan registers
//
// Functional notes
// - Sample-Z: outputs high-Z, boundary register shifts
// - Instruction codes read MSB left, LSB right
// - Code 000: capture ring, shift it, outputs high-Z
// - Identification code: load and shift ID register
// - Identification code loaded at reset and test-logic-reset
// - Sample: capture ring, shift it, no preload
// - Code 111: bypass register, RAM unaffected
// - State moves on TMS at rising TCK
// - Sample-Z also captures ring at Capture-DR
// - Capture-IR loads 01 into two low bits
// - New instruction acts only after Update-IR
// - Sample: Update-DR changes nothing
`timescale 1ns/10ps
`default_nettype none
`include "tap_defines.svh"

module sram_tap_instruction_decode (
  input wire logic clk, // System clock, 250 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic tck, // Test clock pin
  input wire logic tms, // Test mode select pin
  input wire logic tdi, // Test data in pin
  input wire logic [`TAP_BSR_LEN-1:0] ring_in, // I/O ring levels to capture
  output logic tdo, // Test data out
  output logic tdo_oe_n, // TDO drive enable, low while driving
  output logic outputs_hiz, // Force RAM output drivers to high-Z
  output logic [`TAP_IR_W-1:0] instr // Active instruction
);

  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic [`TAP_BSR_LEN-1:0] ring_s;
  logic tck_q;
  tap_pkg::tap_state_type state_q;
  tap_pkg::tap_state_type state_d;
  logic [`TAP_IR_W-1:0] ir_sh_q;
  logic [`TAP_IR_W-1:0] instr_q;
  logic [`TAP_BSR_LEN-1:0] bsr_q;
  logic [`TAP_ID_W-1:0] id_sh_q;
  logic byp_q;
  logic tdo_q;
  logic tdo_oe_n_q;
  logic outputs_hiz_q;

  pin_sync #(.WIDTH(3)) u_ctl_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({tck, tms, tdi}),
    .sync_out({tck_s, tms_s, tdi_s})
  );

  // Ring is only stable if the RAM clock is paused around capture
  pin_sync #(.WIDTH(`TAP_BSR_LEN)) u_ring_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(ring_in),
    .sync_out(ring_s)
  );

  wire tck_rise = tck_s && !tck_q;
  wire tck_fall = !tck_s && tck_q;

  // Decode of the active instruction
  wire ins_extest = (instr_q == `TAP_INS_EXTEST);
  wire ins_id = (instr_q == `TAP_INS_IDCODE);
  wire ins_sample_z = (instr_q == `TAP_INS_SAMPLE_Z);
  wire ins_sample = (instr_q == `TAP_INS_SAMPLE);
  wire sel_bsr = ins_extest || ins_sample_z || ins_sample;
  // Bypass, and every reserved code, shorten the chain to one bit
  wire sel_byp = !sel_bsr && !ins_id;
  wire hiz_d = ins_extest || ins_sample_z;

  wire in_cap_ir = (state_q == tap_pkg::CAPTURE_IR);
  wire in_sh_ir = (state_q == tap_pkg::SHIFT_IR);
  wire in_upd_ir = (state_q == tap_pkg::UPDATE_IR);
  wire in_cap_dr = (state_q == tap_pkg::CAPTURE_DR);
  wire in_sh_dr = (state_q == tap_pkg::SHIFT_DR);
  wire in_tlr = (state_q == tap_pkg::TEST_LOGIC_RESET);

  wire dr_lsb = sel_bsr ? bsr_q[0] : (ins_id ? id_sh_q[0] : byp_q);
  wire tdo_d = in_sh_ir ? ir_sh_q[0] : dr_lsb;

  always_comb begin
    state_d = state_q;
    case (state_q)
      tap_pkg::TEST_LOGIC_RESET: state_d = tms_s ? tap_pkg::TEST_LOGIC_RESET : tap_pkg::RUN_TEST_IDLE;
      tap_pkg::RUN_TEST_IDLE: state_d = tms_s ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
      tap_pkg::SELECT_DR: state_d = tms_s ? tap_pkg::SELECT_IR : tap_pkg::CAPTURE_DR;
      tap_pkg::CAPTURE_DR: state_d = tms_s ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      tap_pkg::SHIFT_DR: state_d = tms_s ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      tap_pkg::EXIT1_DR: state_d = tms_s ? tap_pkg::UPDATE_DR : tap_pkg::PAUSE_DR;
      tap_pkg::PAUSE_DR: state_d = tms_s ? tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
      tap_pkg::EXIT2_DR: state_d = tms_s ? tap_pkg::UPDATE_DR : tap_pkg::SHIFT_DR;
      tap_pkg::UPDATE_DR: state_d = tms_s ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
      tap_pkg::SELECT_IR: state_d = tms_s ? tap_pkg::TEST_LOGIC_RESET : tap_pkg::CAPTURE_IR;
      tap_pkg::CAPTURE_IR: state_d = tms_s ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      tap_pkg::SHIFT_IR: state_d = tms_s ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      tap_pkg::EXIT1_IR: state_d = tms_s ? tap_pkg::UPDATE_IR : tap_pkg::PAUSE_IR;
      tap_pkg::PAUSE_IR: state_d = tms_s ? tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
      tap_pkg::EXIT2_IR: state_d = tms_s ? tap_pkg::UPDATE_IR : tap_pkg::SHIFT_IR;
      tap_pkg::UPDATE_IR: state_d = tms_s ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
      default: state_d = tap_pkg::TEST_LOGIC_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_q <= 1'b0;
      state_q <= tap_pkg::TEST_LOGIC_RESET;
    end else begin
      tck_q <= tck_s;
      if (tck_rise) begin
        state_q <= state_d;
      end
    end
  end

  // Instruction path: shift on rising TCK, apply on falling TCK in Update-IR
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh_q <= `TAP_IR_CAPTURE;
      instr_q <= `TAP_INS_IDCODE;
    end else begin
      if (tck_rise && in_cap_ir) begin
        ir_sh_q <= `TAP_IR_CAPTURE;
      end else if (tck_rise && in_sh_ir) begin
        // LSB leaves first, so the MSB arrives last at the left
        ir_sh_q <= {tdi_s, ir_sh_q[`TAP_IR_W-1:1]};
      end
      if (in_tlr) begin
        instr_q <= `TAP_INS_IDCODE;
      end else if (tck_fall && in_upd_ir) begin
        instr_q <= ir_sh_q;
      end
    end
  end

  // Data registers; no update stage exists, so Update-DR leaves all alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bsr_q <= '0;
      id_sh_q <= `TAP_ID_VALUE;
      byp_q <= 1'b0;
    end else if (tck_rise && in_cap_dr) begin
      if (sel_bsr) begin
        bsr_q <= ring_s;
      end
      if (ins_id) begin
        id_sh_q <= `TAP_ID_VALUE;
      end
      byp_q <= 1'b0;
    end else if (tck_rise && in_sh_dr) begin
      if (sel_bsr) begin
        bsr_q <= {tdi_s, bsr_q[`TAP_BSR_LEN-1:1]};
      end
      if (ins_id) begin
        id_sh_q <= {tdi_s, id_sh_q[`TAP_ID_W-1:1]};
      end
      if (sel_byp) begin
        byp_q <= tdi_s;
      end
    end
  end

  // TDO changes on falling TCK so the far end samples it on the rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_q <= 1'b0;
      tdo_oe_n_q <= 1'b1;
      outputs_hiz_q <= 1'b0;
    end else begin
      outputs_hiz_q <= hiz_d;
      if (tck_fall) begin
        tdo_q <= tdo_d;
        tdo_oe_n_q <= !(in_sh_ir || in_sh_dr);
      end
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe_n = tdo_oe_n_q;
  assign outputs_hiz = outputs_hiz_q;
  assign instr = instr_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_sample_z_hiz;
    ins_sample_z |=> outputs_hiz_q;
  endproperty
  a_sample_z_hiz: assert property (p_sample_z_hiz) else $error("Sample-Z left outputs driven");

  property p_extest_hiz;
    ins_extest |=> outputs_hiz_q;
  endproperty
  a_extest_hiz: assert property (p_extest_hiz) else $error("Code 000 left outputs driven");

  property p_others_drive;
    (ins_id || ins_sample || sel_byp) |=> !outputs_hiz_q;
  endproperty
  a_others_drive: assert property (p_others_drive) else $error("Outputs forced high-Z wrongly");

  property p_tlr_id;
    in_tlr |=> (instr_q == `TAP_INS_IDCODE);
  endproperty
  a_tlr_id: assert property (p_tlr_id) else $error("Reset state did not load ID code");

  property p_cap_ir;
    (tck_rise && in_cap_ir) |=> (ir_sh_q[1:0] == 2'b01);
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("Capture-IR pattern wrong");

  property p_instr_hold;
    !(tck_fall && in_upd_ir) && !in_tlr |=> $stable(instr_q);
  endproperty
  a_instr_hold: assert property (p_instr_hold) else $error("Instruction changed outside Update-IR");

  property p_instr_update;
    (tck_fall && in_upd_ir) |=> (instr_q == $past(ir_sh_q));
  endproperty
  a_instr_update: assert property (p_instr_update) else $error("Update-IR did not apply");

  property p_id_cap;
    (tck_rise && in_cap_dr && ins_id) |=> (id_sh_q == `TAP_ID_VALUE);
  endproperty
  a_id_cap: assert property (p_id_cap) else $error("ID register not loaded");

  property p_bsr_cap;
    (tck_rise && in_cap_dr && sel_bsr) |=> (bsr_q == $past(ring_s));
  endproperty
  a_bsr_cap: assert property (p_bsr_cap) else $error("Ring not captured");

  property p_upd_dr;
    (tck_rise && state_q == tap_pkg::UPDATE_DR) |=> $stable(bsr_q);
  endproperty
  a_upd_dr: assert property (p_upd_dr) else $error("Update-DR altered boundary register");

  property p_byp_tdo;
    (tck_fall && in_sh_dr && sel_byp) |=> (tdo_q == $past(byp_q) && !tdo_oe_n_q);
  endproperty
  a_byp_tdo: assert property (p_byp_tdo) else $error("Bypass bit not on TDO");

  property p_tms_step;
    (tck_rise && in_sh_dr && tms_s) |=> (state_q == tap_pkg::EXIT1_DR);
  endproperty
  a_tms_step: assert property (p_tms_step) else $error("Shift-DR exit on TMS wrong");

  c_update_ir: cover property (tck_fall && in_upd_ir);
  c_sample_z: cover property (ins_sample_z && tck_rise && in_sh_dr);
  c_id_shift: cover property (ins_id && tck_rise && in_sh_dr);
  c_reserved: cover property (sel_byp && instr_q != `TAP_INS_BYPASS && in_sh_dr);

endmodule

`default_nettype wire

// File: tap_defines.svh
// Constants for the scan test port instruction decoder
`ifndef TAP_DEFINES_SVH
`define TAP_DEFINES_SVH

`define TAP_IR_W 3
`define TAP_BSR_LEN 51
`define TAP_ID_W 32

`define TAP_INS_EXTEST 3'h0
`define TAP_INS_IDCODE 3'h1
`define TAP_INS_SAMPLE_Z 3'h2
`define TAP_INS_SAMPLE 3'h4
`define TAP_INS_BYPASS 3'h7

`define TAP_IR_CAPTURE 3'h1
// Arbitrary identification value, bit 0 set as the scan convention expects
`define TAP_ID_VALUE 32'h0000_1001

`endif

// File: tap_pkg.sv
// Types for the scan test port instruction decoder
package tap_pkg;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } tap_state_type;

endpackage

// File: pin_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [WIDTH-1:0] async_in, // Unsynchronised input
  output logic [WIDTH-1:0] sync_out // Synchronised output
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: tap_ctrl_model.sv
// Behavioural board-level scan controller driving the test pins
`timescale 1ns/10ps
`default_nettype none

module tap_ctrl_model (
  output logic tck, // Test clock, still between frames
  output logic tms, // Test mode select
  output logic tdi, // Test data in
  input wire logic tdo // Test data out from the device
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One 125 ns test clock; tdo sampled just before the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #31.25;
    o = tdo;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
    #31.25;
  endtask

  task automatic reset_tap();
    logic o;
    repeat (5) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask

  // Reserved codes only go out when a scenario asks for them
  task automatic ir_shift(input logic [2:0] code, output logic [2:0] cap);
    logic o;
    step(1'b1, ~tdi, o);
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (int i = 0; i < 3; i++) begin
      step(i == 2, code[i], cap[i]);
    end
  endtask

  task automatic ir_update();
    logic o;
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask

  task automatic scan_dr(input logic [63:0] din, output logic [63:0] dout);
    logic o;
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (int i = 0; i < 64; i++) begin
      step(i == 63, din[i], dout[i]);
    end
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
endmodule

`default_nettype wire

// File: sram_tap_instruction_decode_bench.sv
// Self-checking bench for the scan test port instruction decoder
`timescale 1ns/10ps
`default_nettype none
`include "tap_defines.svh"

module sram_tap_instruction_decode_bench;
  logic clk, rst_n, tdo, tdo_oe_n, outputs_hiz;
  wire tck, tms, tdi;
  logic [50:0] ring_in;
  logic [2:0] instr, cur, cap;
  logic [63:0] din, dout, tmp;
  int n_fail, cmp_count, cycles, seed, r;

  sram_tap_instruction_decode dut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .ring_in(ring_in), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .outputs_hiz(outputs_hiz), .instr(instr));
  // Released TDO shows the inverse, so a missing drive enable corrupts the scan
  wire tdo_pin = tdo_oe_n ? ~tdo : tdo;
  tap_ctrl_model m (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));

  always #2 clk = ~clk;

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] %0t mismatch seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Out stream: captured register first, then tdi delayed by its length
  function automatic logic [63:0] want_scan(logic [2:0] c, logic [50:0] ring,
                                            logic [63:0] d);
    logic [63:0] cv;
    int len;
    case (c)
      `TAP_INS_EXTEST, `TAP_INS_SAMPLE_Z, `TAP_INS_SAMPLE: begin
        cv = {13'h0000, ring};
        len = 51;
      end
      `TAP_INS_IDCODE: begin
        cv = {32'h0000_0000, `TAP_ID_VALUE};
        len = 32;
      end
      default: begin
        cv = 64'h0000_0000_0000_0000;
        len = 1;
      end
    endcase
    return (d << len) | (cv & ((64'h0000_0000_0000_0001 << len) - 1));
  endfunction

  function automatic logic want_hiz(logic [2:0] c);
    return c == `TAP_INS_EXTEST || c == `TAP_INS_SAMPLE_Z;
  endfunction

  task automatic run_code(input logic [2:0] code);
    @(negedge clk);
    tmp = {$random(seed), $random(seed)};
    ring_in = tmp[50:0];
    m.ir_shift(code, cap);
    check(cap, 3'h1);
    check(instr, cur);
    m.ir_update();
    cur = code;
    check(instr, code);
    check(outputs_hiz, want_hiz(code));
    check(tdo_oe_n, 1'b1);
    din = {$random(seed), $random(seed)};
    m.scan_dr(din, dout);
    check(dout, want_scan(code, ring_in, din));
    check(outputs_hiz, want_hiz(code));
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ring_in = '0;
    seed = 32'h2880;
    n_fail = 0;
    cmp_count = 0;
    cycles = 0;
    cur = `TAP_INS_IDCODE;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check(instr, `TAP_INS_IDCODE);
    check(outputs_hiz, 1'b0);
    m.reset_tap();
    // Every code, reserved ones included on purpose
    for (int i = 0; i < 8; i++) begin
      run_code(i[2:0]);
    end
    run_code(`TAP_INS_SAMPLE);
    repeat (5) begin
      r = $random(seed);
      run_code(r[2:0]);
    end
    // Leave a high-Z code active so the reset reload is visible
    run_code(`TAP_INS_SAMPLE_Z);
    m.reset_tap();
    check(instr, `TAP_INS_IDCODE);
    check(outputs_hiz, 1'b0);
    final_report();
  end
endmodule

`default_nettype wire
